// [fso_pkg.sv]
// Shared constants and types for the frame sync output configuration block
`default_nettype none
package fso_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MF_PERIOD_NS = 500000;
  localparam int unsigned MF_CYCLES_DEF = MF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAMES_PER_MF = 4;
  localparam int unsigned CNT_W = 17;

  localparam logic [7:0] ADDR_SYNC_PULSE_CFG = 8'h7a;
  localparam logic [7:0] ADDR_FRAME_PHASE_CFG = 8'h7b;
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h7c;

  localparam logic [7:0] RST_SYNC_PULSE_CFG = 8'h00;
  localparam logic [7:0] RST_FRAME_PHASE_CFG = 8'h00;
  localparam logic [7:0] MASK_SYNC_PULSE_CFG = 8'h8f;
  localparam logic [7:0] MASK_FRAME_PHASE_CFG = 8'hc3;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Sampling precision of the external multiframe sync input
  typedef enum logic [1:0] {PREC_6M48, PREC_19M44, PREC_38M88} fso_prec_t;

  typedef struct packed {
    logic src_select;
    logic [2:0] unused;
    logic eight_khz_invert;
    logic eight_khz_pulse_mode;
    logic two_khz_invert;
    logic two_khz_pulse_mode;
  } fso_pulse_cfg_t;

  typedef struct packed {
    logic frame_align_independence;
    logic high_rate_sync_sampling;
    logic [3:0] unused;
    logic [1:0] sync_phase;
  } fso_phase_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fso_reg_req_t;

  typedef struct packed {
    logic last_level;
    logic edge_seen;
  } fso_sampler_state_t;

  typedef struct packed {
    fso_pulse_cfg_t pulse_cfg;
    fso_phase_cfg_t phase_cfg;
    logic [7:0] rdata;
    logic [CNT_W-1:0] cnt;
    logic frame_pulse;
    logic mf_pulse;
    logic two_khz_raw;
    logic two_khz_out;
    logic ocn_resync;
    logic low_rate_resync;
  } fso_state_t;
endpackage
`default_nettype wire

// [fso_sync_sampler.sv]
// Samples the external multiframe sync input and flags its falling edge
`default_nettype none
module fso_sync_sampler (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sample_tick_in,
  input wire logic sync_level_in,
  output logic edge_out
);
  import fso_pkg::*;

  fso_sampler_state_t state_q;
  fso_sampler_state_t state_d;

  // Input only looked at on the selected precision tick
  always_comb begin
    state_d = state_q;
    state_d.edge_seen = 1'b0;
    if (sample_tick_in) begin
      state_d.last_level = sync_level_in;
      state_d.edge_seen = state_q.last_level & ~sync_level_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign edge_out = state_q.edge_seen;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  edge_only_tick_a: assert property (edge_out |-> $past(sample_tick_in))
    else $error("sync edge flagged without a sample tick");
endmodule // fso_sync_sampler
`default_nettype wire

// [fso_frame_sync.sv]
// Frame and multiframe sync output generation with register configuration
`default_nettype none
module fso_frame_sync #(
  parameter int unsigned MF_CYCLES = fso_pkg::MF_CYCLES_DEF
) (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic EXT_SYNC_IN,
  input wire logic REF_IS_19M44_IN,
  input wire logic TICK_6M48_IN,
  input wire logic TICK_19M44_IN,
  input wire logic TICK_38M88_IN,
  input wire logic PW_CLK_EN_IN,
  input wire logic PW_CLK_TICK_IN,
  output logic FRAME_PULSE_OUT,
  output logic MULTIFRAME_PULSE_OUT,
  output logic TWO_KHZ_SYNC_OUT,
  output logic OCN_RESYNC_OUT,
  output logic LOW_RATE_RESYNC_OUT
);
  import fso_pkg::*;

  localparam logic [CNT_W-1:0] MF_LAST = CNT_W'(MF_CYCLES - 1);
  localparam logic [CNT_W-1:0] MF_HALF = CNT_W'(MF_CYCLES / 2);
  localparam logic [CNT_W-1:0] FRAME_LEN = CNT_W'(MF_CYCLES / FRAMES_PER_MF);

  // All state lives in one struct so the next value is built in one place only
  fso_state_t state_q;
  fso_state_t state_d;
  fso_reg_req_t req;
  fso_prec_t prec_sel;
  logic sample_tick;
  logic sync_edge;
  logic pulsed_mode;

  // Precision choice depends only on the high-rate bit and the reference
  function automatic fso_prec_t pick_precision(input logic high_rate, input logic ref_19m44);
    if (!high_rate) begin
      pick_precision = PREC_6M48;
    end else if (ref_19m44) begin
      pick_precision = PREC_19M44;
    end else begin
      pick_precision = PREC_38M88;
    end
  endfunction

  // True on the first cycle of each of the four frames in a multiframe
  function automatic logic is_frame_start(input logic [CNT_W-1:0] cnt);
    logic hit;
    hit = 1'b0;
    for (int unsigned i = 0; i < FRAMES_PER_MF; i++) begin
      if (cnt == CNT_W'(i * FRAME_LEN)) begin
        hit = 1'b1;
      end
    end
    is_frame_start = hit;
  endfunction

  assign req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};

  // Sample strobe chosen by precision
  always_comb begin
    prec_sel = pick_precision(state_q.phase_cfg.high_rate_sync_sampling, REF_IS_19M44_IN);
    case (prec_sel)
      PREC_6M48: sample_tick = TICK_6M48_IN;
      PREC_19M44: sample_tick = TICK_19M44_IN;
      PREC_38M88: sample_tick = TICK_38M88_IN;
      default: sample_tick = TICK_38M88_IN;
    endcase
  end

  fso_sync_sampler u_sampler (
    .clk_in(MCLK_IN),
    .reset_n_in(RESET_N_IN),
    .sample_tick_in(sample_tick),
    .sync_level_in(EXT_SYNC_IN),
    .edge_out(sync_edge)
  );

  // Pulsed form needs the width clock running; without it fall back to square
  assign pulsed_mode = state_q.pulse_cfg.two_khz_pulse_mode & PW_CLK_EN_IN;

  // Next-state logic: registers, multiframe counter, outputs
  always_comb begin
    state_d = state_q;
    state_d.rdata = RDATA_IDLE;
    // Reserved bits are dropped at the write so they always read back as zero
    if (req.wr) begin
      case (req.addr)
        ADDR_SYNC_PULSE_CFG: state_d.pulse_cfg = fso_pulse_cfg_t'(req.wdata & MASK_SYNC_PULSE_CFG);
        ADDR_FRAME_PHASE_CFG: state_d.phase_cfg = fso_phase_cfg_t'(req.wdata & MASK_FRAME_PHASE_CFG);
        default: ;
      endcase
    end
    // Reads answer from registered state, one cycle after the strobe
    if (req.rd) begin
      case (req.addr)
        ADDR_SYNC_PULSE_CFG: state_d.rdata = state_q.pulse_cfg;
        ADDR_FRAME_PHASE_CFG: state_d.rdata = state_q.phase_cfg;
        ADDR_SYNC_STATUS: state_d.rdata = {5'h00, state_q.two_khz_out, prec_sel};
        default: state_d.rdata = RDATA_IDLE;
      endcase
    end
    // A sync edge restarts the multiframe; frame outputs follow it always
    if (sync_edge) begin
      state_d.cnt = '0;
    end else if (state_q.cnt >= MF_LAST) begin
      state_d.cnt = '0;
    end else begin
      state_d.cnt = state_q.cnt + CNT_W'(1);
    end
    state_d.frame_pulse = is_frame_start(state_d.cnt);
    state_d.mf_pulse = (state_d.cnt == '0);
    if (pulsed_mode) begin
      // Start wins over a coinciding width tick so the pulse is never lost
      if (state_d.cnt == '0) begin
        state_d.two_khz_raw = 1'b1;
      end else if (PW_CLK_TICK_IN) begin
        state_d.two_khz_raw = 1'b0;
      end
    end else begin
      state_d.two_khz_raw = (state_d.cnt < MF_HALF);
    end
    state_d.two_khz_out = state_d.two_khz_raw ^ state_q.pulse_cfg.two_khz_invert;
    // Other clocks only disturbed when frame alignment is kept to them
    state_d.low_rate_resync = sync_edge & ~state_q.phase_cfg.frame_align_independence;
    state_d.ocn_resync = sync_edge & ~state_q.phase_cfg.frame_align_independence
                         & state_q.phase_cfg.high_rate_sync_sampling;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      state_q <= '{pulse_cfg: fso_pulse_cfg_t'(RST_SYNC_PULSE_CFG),
                   phase_cfg: fso_phase_cfg_t'(RST_FRAME_PHASE_CFG),
                   default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign REG_RDATA_OUT = state_q.rdata;
  assign FRAME_PULSE_OUT = state_q.frame_pulse;
  assign MULTIFRAME_PULSE_OUT = state_q.mf_pulse;
  assign TWO_KHZ_SYNC_OUT = state_q.two_khz_out;
  assign OCN_RESYNC_OUT = state_q.ocn_resync;
  assign LOW_RATE_RESYNC_OUT = state_q.low_rate_resync;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence edge_under_cfg;
    sync_edge;
  endsequence

  // Both frame outputs restart together with the counter
  sequence realigned;
    MULTIFRAME_PULSE_OUT && FRAME_PULSE_OUT && state_q.cnt == '0;
  endsequence

  pulse_end_tick_a: assert property (pulsed_mode && state_q.two_khz_raw && PW_CLK_TICK_IN && state_d.cnt != '0
      |=> !state_q.two_khz_raw)
    else $error("2 kHz pulse outlived one width clock period");
  pulse_start_a: assert property (pulsed_mode && state_d.cnt == '0 |=> state_q.two_khz_raw)
    else $error("2 kHz pulse missing at multiframe start");
  square_half_a: assert property (!pulsed_mode && !sync_edge && state_q.cnt == MF_HALF - CNT_W'(1)
      |=> !state_q.two_khz_raw ##1 !state_q.two_khz_raw)
    else $error("square wave not low in second half");
  realign_frame_a: assert property (edge_under_cfg |=> realigned)
    else $error("frame outputs not realigned to sync edge");
  align_all_a: assert property (edge_under_cfg and !state_q.phase_cfg.frame_align_independence
      |=> LOW_RATE_RESYNC_OUT and realigned)
    else $error("other clocks not resynced with frame outputs");
  indep_quiet_a: assert property (state_q.phase_cfg.frame_align_independence && $stable(state_q.phase_cfg)
      |=> !LOW_RATE_RESYNC_OUT && !OCN_RESYNC_OUT)
    else $error("independent mode disturbed other clocks");
  ocn_off_a: assert property (!state_q.phase_cfg.high_rate_sync_sampling |=> !OCN_RESYNC_OUT)
    else $error("OC-N clocks resynced with high-rate sync off");
  ocn_resync_a: assert property (edge_under_cfg and state_q.phase_cfg.high_rate_sync_sampling
      and !state_q.phase_cfg.frame_align_independence |=> OCN_RESYNC_OUT)
    else $error("OC-N clocks not resynced");
  prec_pick_a: assert property (state_q.phase_cfg.high_rate_sync_sampling
      |-> prec_sel == (REF_IS_19M44_IN ? PREC_19M44 : PREC_38M88))
    else $error("wrong high-rate sampling precision");
  prec_low_a: assert property (!state_q.phase_cfg.high_rate_sync_sampling |-> sample_tick == TICK_6M48_IN)
    else $error("low-rate sampling not on 6.48 MHz tick");

  // Counter, square-wave and cross-output checks: a resync pulse without a realigned
  // multiframe would leave downstream clocks out of step with the frames
  mf_wrap_a: assert property (state_q.cnt == MF_LAST && !sync_edge |=> MULTIFRAME_PULSE_OUT)
    else $error("multiframe did not restart after its last cycle");
  cnt_range_a: assert property (state_q.cnt <= MF_LAST)
    else $error("multiframe counter ran past its last cycle");
  mf_with_frame_a: assert property (MULTIFRAME_PULSE_OUT |-> FRAME_PULSE_OUT)
    else $error("multiframe start without frame start");
  resync_with_frame_a: assert property (LOW_RATE_RESYNC_OUT |-> MULTIFRAME_PULSE_OUT && FRAME_PULSE_OUT)
    else $error("other clocks resynced without frame realignment");
  ocn_with_frame_a: assert property (OCN_RESYNC_OUT |-> LOW_RATE_RESYNC_OUT && FRAME_PULSE_OUT)
    else $error("OC-N clocks resynced apart from frame outputs");
  square_level_a: assert property (!pulsed_mode |=> state_q.two_khz_raw == (state_q.cnt < MF_HALF))
    else $error("square wave level does not follow the multiframe half");
  // Read data must not linger: a stale value would be taken for a second read
  rd_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == RDATA_IDLE)
    else $error("read data stood longer than one cycle");
endmodule // fso_frame_sync
`default_nettype wire

// [fso_framer_model.sv]
// Downstream framer model: counts frame starts in each multiframe
`default_nettype none
module fso_framer_model (
  input wire logic clk_in,
  input wire logic frame_in,
  input wire logic multiframe_in,
  output var int frames_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int run = 0;
  // Latch the finished count at each start; a resync mid-run leaves a short count
  always @(posedge clk_in) begin
    if (multiframe_in === 1'b1) begin
      frames_out <= run;
      run <= (frame_in === 1'b1) ? 1 : 0;
    end else if (frame_in === 1'b1) begin
      run <= run + 1;
    end
  end
endmodule // fso_framer_model
`default_nettype wire

// [fso_frame_sync_test.sv]
// Self-checking bench for the frame sync output configuration block
`default_nettype none
module fso_frame_sync_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fso_pkg::*;
  localparam int MF = 40;
  // {independence, high rate, ref is 19.44}
  localparam logic [2:0] CASES [8] = '{3'b000, 3'b001, 3'b011, 3'b010, 3'b101, 3'b111, 3'b110, 3'b100};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b1;
  logic ref19 = 1'b0;
  logic pw_en = 1'b0;
  logic pw_tick = 1'b0;
  logic [2:0] tick = 3'h0;
  logic [7:0] rdata;
  logic fr, mf, two, ocn, lrr;
  int fpm;
  int n_fail = 0;
  int checks = 0;
  int seed = 32'h171b;

  always #2.5 clk = ~clk;
  // Random width-clock boundaries so pulse widths vary from period to period
  always @(posedge clk) pw_tick <= ($random(seed) % 4 == 0);

  fso_frame_sync #(.MF_CYCLES(MF)) uut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .EXT_SYNC_IN(ext),
    .REF_IS_19M44_IN(ref19), .TICK_6M48_IN(tick[0]), .TICK_19M44_IN(tick[1]), .TICK_38M88_IN(tick[2]),
    .PW_CLK_EN_IN(pw_en), .PW_CLK_TICK_IN(pw_tick), .FRAME_PULSE_OUT(fr), .MULTIFRAME_PULSE_OUT(mf),
    .TWO_KHZ_SYNC_OUT(two), .OCN_RESYNC_OUT(ocn), .LOW_RATE_RESYNC_OUT(lrr));
  fso_framer_model framer (.clk_in(clk), .frame_in(fr), .multiframe_in(mf), .frames_out(fpm));

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpb(input string what, input logic exp, input logic got);
    cmp(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, then idle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(what, exp, rdata);
    @(negedge clk);
    cmp("read idle", RDATA_IDLE, rdata);
  endtask
  task automatic wait_mf;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (mf !== 1'b1 && k < 100);
    cmpb("multiframe wait", 1'b1, mf);
  endtask
  // One whole multiframe: length, high time of the 2 kHz output, frames seen downstream
  task automatic period(input bit pulsed, input bit inv);
    int n, hi, t;
    n = 0;
    hi = 0;
    t = -1;
    wait_mf;
    do begin
      if ((two ^ inv) === 1'b1) hi++;
      if (t < 0 && pw_tick === 1'b1) t = n;
      n++;
      @(negedge clk);
    end while (mf !== 1'b1 && n < 100);
    cnt("period", MF, n);
    cnt("high time", pulsed ? t + 1 : MF / 2, hi);
    @(negedge clk);
    cnt("frames", int'(FRAMES_PER_MF), fpm);
  endtask
  // Falling edge of the sync input, seen only by the ticks in tk; started early in a multiframe
  task automatic sync_evt(input logic [2:0] tk, input logic hit, input logic b7, input logic b6);
    wait_mf;
    @(posedge clk);
    tick <= tk;
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    @(posedge clk);
    tick <= 3'h0;
    @(posedge clk);
    @(negedge clk);
    cmpb("multiframe", hit, mf);
    cmpb("frame", hit, fr);
    cmpb("low rate resync", hit & ~b7, lrr);
    cmpb("ocn resync", hit & ~b7 & b6, ocn);
    cmpb("two khz", 1'b1, two);
    @(negedge clk);
    cmpb("multiframe end", 1'b0, mf);
  endtask

  // Watchdog: the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("Watchdog expired");
    finish_test;
  end

  // Main sequence
  initial begin
    int sel;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_SYNC_PULSE_CFG, RST_SYNC_PULSE_CFG, "pulse cfg reset");
    rd_chk(ADDR_FRAME_PHASE_CFG, RST_FRAME_PHASE_CFG, "phase cfg reset");
    wr_reg(ADDR_SYNC_PULSE_CFG, 8'hff);
    rd_chk(ADDR_SYNC_PULSE_CFG, MASK_SYNC_PULSE_CFG, "pulse cfg mask");
    wr_reg(ADDR_FRAME_PHASE_CFG, 8'hff);
    rd_chk(ADDR_FRAME_PHASE_CFG, MASK_FRAME_PHASE_CFG, "phase cfg mask");
    wr_reg(8'h7d, 8'hff);
    rd_chk(8'h7d, RDATA_IDLE, "unmapped");
    $display("Register test done");
    wr_reg(ADDR_SYNC_PULSE_CFG, 8'h00);
    period(1'b0, 1'b0);
    @(posedge clk);
    pw_en <= 1'b1;
    wr_reg(ADDR_SYNC_PULSE_CFG, 8'h01);
    period(1'b1, 1'b0);
    wr_reg(ADDR_SYNC_PULSE_CFG, 8'h03);
    period(1'b1, 1'b1);
    @(posedge clk);
    pw_en <= 1'b0;
    period(1'b0, 1'b1);
    wr_reg(ADDR_SYNC_PULSE_CFG, 8'h00);
    $display("Two kHz test done");
    foreach (CASES[i]) begin
      sel = !CASES[i][1] ? 0 : (CASES[i][0] ? 1 : 2);
      @(posedge clk);
      // Reference kept off 19.44 while high-rate sampling is off
      ref19 <= CASES[i][0] & CASES[i][1];
      wr_reg(ADDR_FRAME_PHASE_CFG, {CASES[i][2:1], 6'h00});
      wait_mf;
      rd_chk(ADDR_SYNC_STATUS, {5'h00, 1'b1, 2'(sel)}, "status");
      sync_evt(3'h7 & ~(3'h1 << sel), 1'b0, CASES[i][2], CASES[i][1]);
      sync_evt(3'h1 << sel, 1'b1, CASES[i][2], CASES[i][1]);
    end
    period(1'b0, 1'b0);
    $display("Sync test done");
    finish_test;
  end
endmodule // fso_frame_sync_test
`default_nettype wire
